/* File: rtl/gaq_regs.sv */
// Purpose: APB register bank, command queue, host byte collector and a
//          small X/Y stepping engine for the graphics accelerator.
// Assumes: Single clock pclk, APB3 slave, one byte processed per cycle.
// Notes:   pready is registered, so every access has at least one wait state.
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ns
`include "gaq_defs.svh"

module gaq_regs
  import gaq_pkg::*;
(
  input  wire logic        pclk,     // System clock, 25 MHz
  input  wire logic        presetn,  // Asynchronous reset, active low
  input  wire logic        ce,       // Clock enable, freezes state when low
  input  wire logic        psel,     // APB select
  input  wire logic        penable,  // APB access phase
  input  wire logic        pwrite,   // APB direction
  input  wire logic [9:0]  paddr,    // APB byte address
  input  wire logic [31:0] pwdata,   // APB write data
  output logic      [31:0] prdata,   // APB read data
  output logic             pready,   // APB ready
  output logic             pslverr   // APB error on unmapped index
);

  localparam int QD = 4;

  gaq_eng_state_t       eng_ff;
  logic [31:0]          prdata_ff;
  logic                 pready_ff;
  logic                 pslverr_ff;
  logic                 sync_en_ff;
  logic [2:0]           irq_mask_ff;
  logic                 wfault_ff;
  logic                 rdirq_ff;
  logic                 block_ff;
  logic                 screen_ff;
  logic                 busy_prev_ff;
  logic [7:0]           q_idx_ff [QD];
  logic [31:0]          q_dat_ff [QD];
  logic [1:0]           q_wp_ff;
  logic [1:0]           q_rp_ff;
  logic [2:0]           q_cnt_ff;
  logic [21:0]          pat_base_ff;
  logic [21:0]          src_base_ff;
  logic [11:0]          pat_off_ff;
  logic [11:0]          src_off_ff;
  logic [11:0]          dst_off_ff;
  logic [1:0]           hwidth_ff;
  logic [1:0]           dir_ff;
  logic [6:0]           pwrap_ff;
  logic [31:0]          ctrl_ff;
  logic [1:0]           hbyte_ff;
  logic [31:0]          hword_ff;
  logic [31:0]          hcoll_ff;
  logic [21:0]          haddr_ff;
  logic [7:0]           hpos_ff;
  logic [7:0]           vpos_ff;
  logic [6:0]           hx_ff;
  logic [3:0]           vy_ff;
  logic [21:0]          pat_ptr_ff;
  logic [21:0]          pat_row_ff;
  logic [21:0]          src_ptr_ff;
  logic [21:0]          dst_ptr_ff;
  logic [7:0]           idx;
  logic                 take;
  logic                 wr_take;
  logic                 q_full;
  logic                 q_wr;
  logic                 push;
  logic                 pop;
  logic                 busy;
  logic                 stall;
  logic                 nxt_pready;
  logic [31:0]          nxt_prdata;
  logic                 start;
  logic                 last_x;
  logic                 last_y;
  logic [6:0]           hlen;
  logic [3:0]           vlen;
  logic                 host_src;
  logic                 hxfer;

  // Index decode for the error answer; the queued subset also gates queue writes
  function automatic logic gaq_mapped(input logic [7:0] i);
    case (i)
      `GAQ_IDX_SYNC_EN, `GAQ_IDX_IRQ_MASK, `GAQ_IDX_IRQ_STAT,
      `GAQ_IDX_STATUS, `GAQ_IDX_CTRL, `GAQ_IDX_HDATA, `GAQ_IDX_HADDR,
      `GAQ_IDX_PAT_PTR: gaq_mapped = 1'b1;
      default: gaq_mapped = gaq_queued(i);
    endcase
  endfunction

  function automatic logic gaq_queued(input logic [7:0] i);
    case (i)
      `GAQ_IDX_PAT_BASE, `GAQ_IDX_SRC_BASE, `GAQ_IDX_PAT_OFF,
      `GAQ_IDX_SRC_OFF, `GAQ_IDX_DST_OFF, `GAQ_IDX_HWIDTH, `GAQ_IDX_DIR,
      `GAQ_IDX_PAT_WRAP: gaq_queued = 1'b1;
      default: gaq_queued = 1'b0;
    endcase
  endfunction

  // Pointer step of amount in the chosen direction
  function automatic logic [21:0] gaq_step(input logic [21:0] a,
                                           input logic [12:0] amt,
                                           input logic        neg);
    gaq_step = neg ? a - {9'h000, amt} : a + {9'h000, amt};
  endfunction

  // Horizontal wrap length in bytes, zero for none or reserved
  function automatic logic [6:0] gaq_hlen(input logic [2:0] c);
    case (c)
      3'h2: gaq_hlen = 7'h04;
      3'h3: gaq_hlen = 7'h08;
      3'h4: gaq_hlen = 7'h10;
      3'h5: gaq_hlen = 7'h20;
      3'h6: gaq_hlen = 7'h40;
      default: gaq_hlen = 7'h00;
    endcase
  endfunction

  // Vertical wrap length in lines, zero for reserved codes
  function automatic logic [3:0] gaq_vlen(input logic [2:0] c);
    case (c)
      3'h0: gaq_vlen = 4'h1;
      3'h1: gaq_vlen = 4'h2;
      3'h2: gaq_vlen = 4'h4;
      3'h3: gaq_vlen = 4'h8;
      default: gaq_vlen = 4'h0;
    endcase
  endfunction

  // Address increment per host transfer
  function automatic logic [5:0] gaq_incr(input logic [1:0] w,
                                          input logic [1:0] aroute,
                                          input logic [2:0] droute);
    case (droute)
      3'h0: gaq_incr = (aroute == 2'h1) ? 6'h01 : 6'h00;
      3'h1: gaq_incr = 6'h01 << w;
      3'h2: gaq_incr = 6'h08 << w;
      default: gaq_incr = 6'h00;
    endcase
  endfunction

  assign idx      = paddr[9:2];
  assign take     = ce && psel && penable && pready_ff;
  assign wr_take  = take && pwrite && !pslverr_ff;
  assign q_full   = (q_cnt_ff == `GAQ_QDEPTH);
  assign q_wr     = pwrite && gaq_queued(idx);
  assign push     = wr_take && gaq_queued(idx) && !q_full;
  assign pop      = (eng_ff == GAQ_ENG_IDLE) && (q_cnt_ff != 3'h0);
  assign busy     = (eng_ff == GAQ_ENG_RUN) || (q_cnt_ff != 3'h0);
  // Sync mode wait-states a write to a full queue instead of dropping it
  assign stall    = q_wr && q_full && sync_en_ff;
  assign start    = wr_take && (idx == `GAQ_IDX_CTRL)
                    && pwdata[`GAQ_CTL_START] && !busy;
  assign last_x   = (hpos_ff == ctrl_ff[`GAQ_CTL_HCOUNT_LSB +: 8]);
  assign last_y   = (vpos_ff == ctrl_ff[`GAQ_CTL_VCOUNT_LSB +: 8]);
  assign hlen     = gaq_hlen(pwrap_ff[2:0]);
  assign vlen     = gaq_vlen(pwrap_ff[`GAQ_VWRAP_LSB +: 3]);
  assign host_src = (ctrl_ff[`GAQ_CTL_DROUTE_LSB +: 3] == 3'h1);
  assign hxfer    = wr_take && (idx == `GAQ_IDX_HDATA)
                    && (hbyte_ff == ((2'h1 << hwidth_ff) - 2'h1));

  always_comb begin
    nxt_pready = ce && psel && penable && !pready_ff && !stall;
    nxt_prdata = 32'h0000_0000;
    case (idx)
      `GAQ_IDX_SYNC_EN:  nxt_prdata = {31'h0, sync_en_ff};
      `GAQ_IDX_IRQ_MASK: nxt_prdata = {29'h0, irq_mask_ff};
      `GAQ_IDX_IRQ_STAT: nxt_prdata = {29'h0, wfault_ff, rdirq_ff,
                                       irq_mask_ff[`GAQ_IRQ_WRITE]
                                       && !q_full};
      `GAQ_IDX_STATUS:   nxt_prdata = {28'h0, screen_ff, block_ff, busy,
                                       q_full};
      `GAQ_IDX_CTRL:     nxt_prdata = {ctrl_ff[31:1], 1'b0};
      `GAQ_IDX_HDATA:    nxt_prdata = hword_ff;
      `GAQ_IDX_HADDR:    nxt_prdata = {10'h000, haddr_ff};
      `GAQ_IDX_PAT_PTR:  nxt_prdata = {10'h000, pat_ptr_ff};
      `GAQ_IDX_PAT_BASE: nxt_prdata = {10'h000, pat_base_ff};
      `GAQ_IDX_SRC_BASE: nxt_prdata = {10'h000, src_base_ff};
      `GAQ_IDX_PAT_OFF:  nxt_prdata = {20'h00000, pat_off_ff};
      `GAQ_IDX_SRC_OFF:  nxt_prdata = {20'h00000, src_off_ff};
      `GAQ_IDX_DST_OFF:  nxt_prdata = {20'h00000, dst_off_ff};
      `GAQ_IDX_HWIDTH:   nxt_prdata = {30'h0, hwidth_ff};
      `GAQ_IDX_DIR:      nxt_prdata = {30'h0, dir_ff};
      `GAQ_IDX_PAT_WRAP: nxt_prdata = {25'h0, pwrap_ff};
      default:           nxt_prdata = 32'h0000_0000;
    endcase
  end

  // APB answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= `GAQ_RST_ZERO32;
    end else if (ce) begin
      pready_ff  <= nxt_pready;
      pslverr_ff <= nxt_pready && !gaq_mapped(idx);
      if (nxt_pready) begin
        prdata_ff <= pwrite ? 32'h0000_0000 : nxt_prdata;
      end
    end
  end

  // Non-queued control and interrupt flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_en_ff   <= 1'b0;
      irq_mask_ff  <= 3'h0;
      wfault_ff    <= 1'b0;
      rdirq_ff     <= 1'b0;
      busy_prev_ff <= 1'b0;
    end else if (ce) begin
      busy_prev_ff <= busy;
      if (wr_take && idx == `GAQ_IDX_SYNC_EN) begin
        sync_en_ff <= pwdata[0];
      end
      if (wr_take && idx == `GAQ_IDX_IRQ_MASK) begin
        irq_mask_ff <= pwdata[2:0];
      end
      // A new event beats a clear in the same cycle
      if (wr_take && q_wr && q_full && irq_mask_ff[`GAQ_IRQ_WFAULT]) begin
        wfault_ff <= 1'b1;
      end else if (wr_take && idx == `GAQ_IDX_IRQ_STAT
                   && pwdata[`GAQ_IRQ_WFAULT]) begin
        wfault_ff <= 1'b0;
      end
      if (busy_prev_ff && !busy && irq_mask_ff[`GAQ_IRQ_READ]) begin
        rdirq_ff <= 1'b1;
      end else if (wr_take && idx == `GAQ_IDX_IRQ_STAT
                   && pwdata[`GAQ_IRQ_READ]) begin
        rdirq_ff <= 1'b0;
      end
    end
  end

  // Command queue; writes while full are dropped (or stalled in sync mode)
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_wp_ff  <= 2'h0;
      q_rp_ff  <= 2'h0;
      q_cnt_ff <= 3'h0;
      for (int i = 0; i < QD; i++) begin
        q_idx_ff[i] <= 8'h00;
        q_dat_ff[i] <= `GAQ_RST_ZERO32;
      end
    end else if (ce) begin
      if (push) begin
        q_idx_ff[q_wp_ff] <= idx;
        q_dat_ff[q_wp_ff] <= pwdata;
        q_wp_ff           <= q_wp_ff + 2'h1;
      end
      if (pop) begin
        q_rp_ff <= q_rp_ff + 2'h1;
      end
      q_cnt_ff <= q_cnt_ff + {2'h0, push} - {2'h0, pop};
    end
  end

  // Engine copies of the queued parameters, loaded only while idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pat_base_ff <= 22'h000000;
      src_base_ff <= 22'h000000;
      pat_off_ff  <= 12'h000;
      src_off_ff  <= 12'h000;
      dst_off_ff  <= 12'h000;
      hwidth_ff   <= 2'h0;
      dir_ff      <= `GAQ_RST_DIR;
      pwrap_ff    <= `GAQ_RST_WRAP;
    end else if (ce && pop) begin
      case (q_idx_ff[q_rp_ff])
        `GAQ_IDX_PAT_BASE: pat_base_ff <= q_dat_ff[q_rp_ff][21:0];
        `GAQ_IDX_SRC_BASE: src_base_ff <= q_dat_ff[q_rp_ff][21:0];
        `GAQ_IDX_PAT_OFF:  pat_off_ff  <= q_dat_ff[q_rp_ff][11:0];
        `GAQ_IDX_SRC_OFF:  src_off_ff  <= q_dat_ff[q_rp_ff][11:0];
        `GAQ_IDX_DST_OFF:  dst_off_ff  <= q_dat_ff[q_rp_ff][11:0];
        `GAQ_IDX_HWIDTH:   hwidth_ff   <= q_dat_ff[q_rp_ff][1:0];
        `GAQ_IDX_DIR:      dir_ff      <= q_dat_ff[q_rp_ff][1:0];
        `GAQ_IDX_PAT_WRAP: pwrap_ff    <= q_dat_ff[q_rp_ff][6:0] & 7'h77;
        default:           pat_base_ff <= pat_base_ff;
      endcase
    end
  end

  // Host byte collector; reserved width code 11 collects 4 bytes, but its address step is 8 for DROUTE 1 and 0 for DROUTE 2
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hbyte_ff <= 2'h0;
      hcoll_ff <= `GAQ_RST_ZERO32;
      hword_ff <= `GAQ_RST_ZERO32;
      haddr_ff <= 22'h000000;
    end else if (ce) begin
      if (wr_take && idx == `GAQ_IDX_HADDR) begin
        haddr_ff <= pwdata[21:0];
      end else if (hxfer) begin
        haddr_ff <= gaq_step(haddr_ff,
                      {7'h00, gaq_incr(hwidth_ff,
                        ctrl_ff[`GAQ_CTL_AROUTE_LSB +: 2],
                        ctrl_ff[`GAQ_CTL_DROUTE_LSB +: 3])},
                      dir_ff[0]);
      end
      if (wr_take && idx == `GAQ_IDX_HDATA) begin
        hcoll_ff[{hbyte_ff, 3'h0} +: 8] <= pwdata[7:0];
        if (hxfer) begin
          hbyte_ff <= 2'h0;
          hword_ff <= hcoll_ff;
          hword_ff[{hbyte_ff, 3'h0} +: 8] <= pwdata[7:0];
        end else begin
          hbyte_ff <= hbyte_ff + 2'h1;
        end
      end
    end
  end

  // Engine control word and status flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff   <= `GAQ_RST_ZERO32;
      block_ff  <= 1'b0;
      screen_ff <= 1'b0;
    end else if (ce) begin
      if (wr_take && idx == `GAQ_IDX_CTRL && !busy) begin
        ctrl_ff <= {pwdata[31:1], 1'b0};
      end
      if (start) begin
        block_ff  <= 1'b1;
        screen_ff <= pwdata[`GAQ_CTL_SCREEN];
      end else if (eng_ff == GAQ_ENG_RUN && last_x && last_y) begin
        block_ff  <= 1'b0;
        screen_ff <= 1'b0;
      end else if (wr_take && idx == `GAQ_IDX_STATUS) begin
        block_ff <= pwdata[`GAQ_ST_BLOCK];
      end
    end
  end

  // X/Y stepping with pattern tiling, one byte per cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eng_ff     <= GAQ_ENG_IDLE;
      hpos_ff    <= 8'h00;
      vpos_ff    <= 8'h00;
      hx_ff      <= 7'h00;
      vy_ff      <= 4'h0;
      pat_ptr_ff <= 22'h000000;
      pat_row_ff <= 22'h000000;
      src_ptr_ff <= 22'h000000;
      dst_ptr_ff <= 22'h000000;
    end else if (ce) begin
      case (eng_ff)
        GAQ_ENG_IDLE: begin
          if (start) begin
            eng_ff     <= GAQ_ENG_RUN;
            hpos_ff    <= 8'h00;
            vpos_ff    <= 8'h00;
            hx_ff      <= 7'h00;
            vy_ff      <= 4'h0;
            pat_ptr_ff <= pat_base_ff;
            pat_row_ff <= pat_base_ff;
            src_ptr_ff <= src_base_ff;
            dst_ptr_ff <= haddr_ff;
          end
        end
        GAQ_ENG_RUN: begin
          if (last_x && last_y) begin
            eng_ff <= GAQ_ENG_IDLE;
          end else if (last_x) begin
            hpos_ff <= 8'h00;
            vpos_ff <= vpos_ff + 8'h01;
            hx_ff   <= 7'h00;
            if (vlen != 4'h0 && vy_ff == vlen - 4'h1) begin
              vy_ff      <= 4'h0;
              pat_row_ff <= pat_base_ff;
              pat_ptr_ff <= pat_base_ff;
            end else begin
              vy_ff      <= vy_ff + 4'h1;
              pat_row_ff <= gaq_step(pat_row_ff,
                              {1'b0, pat_off_ff} + 13'h0001,
                              dir_ff[1]);
              pat_ptr_ff <= gaq_step(pat_row_ff,
                              {1'b0, pat_off_ff} + 13'h0001, dir_ff[1]);
            end
            if (!host_src) begin
              src_ptr_ff <= gaq_step(src_ptr_ff,
                              {1'b0, src_off_ff} + 13'h0001,
                              dir_ff[1]);
            end
            dst_ptr_ff <= gaq_step(dst_ptr_ff,
                            {1'b0, dst_off_ff} + 13'h0001, dir_ff[1]);
          end else begin
            hpos_ff <= hpos_ff + 8'h01;
            if (hlen != 7'h00 && hx_ff == hlen - 7'h01) begin
              hx_ff      <= 7'h00;
              pat_ptr_ff <= pat_row_ff;
            end else begin
              hx_ff      <= hx_ff + 7'h01;
              pat_ptr_ff <= gaq_step(pat_ptr_ff, 13'h0001, dir_ff[0]);
            end
            if (!host_src) begin
              src_ptr_ff <= gaq_step(src_ptr_ff, 13'h0001, dir_ff[0]);
            end
            dst_ptr_ff <= gaq_step(dst_ptr_ff, 13'h0001, dir_ff[0]);
          end
        end
        default: eng_ff <= GAQ_ENG_IDLE;
      endcase
    end
  end

  assign prdata  = prdata_ff;
  assign pready  = pready_ff;
  assign pslverr = pslverr_ff;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_full_drops_push: assert property (
    (wr_take && q_wr && q_full && !pop)
      |=> (q_cnt_ff == $past(q_cnt_ff)))
    else $error("write to full queue was stored");
  a_fault_sets: assert property (
    (wr_take && q_wr && q_full && irq_mask_ff[2]) |=> wfault_ff)
    else $error("write fault flag not set");
  a_read_clear: assert property (
    (wr_take && idx == `GAQ_IDX_IRQ_STAT && pwdata[1]
      && !(busy_prev_ff && !busy && irq_mask_ff[1])) |=> !rdirq_ff)
    else $error("read flag not cleared by one");
  a_read_irq_edge: assert property (
    (ce && busy_prev_ff && !busy && irq_mask_ff[1]) |=> rdirq_ff)
    else $error("read flag missed busy fall");
  a_write_irq_level: assert property (
    (take && !pwrite && idx == `GAQ_IDX_IRQ_STAT)
      |-> (prdata_ff[0] == $past(irq_mask_ff[0] && !q_full)))
    else $error("write flag not tracking queue");
  a_busy_status: assert property (
    (take && !pwrite && idx == `GAQ_IDX_STATUS)
      |-> (prdata_ff[1] == $past(busy)))
    else $error("busy status mismatch");
  a_sync_wait: assert property (
    (ce && psel && penable && !pready_ff && stall) |=> !pready_ff)
    else $error("full sync write not stalled");
  a_block_done: assert property (
    (ce && eng_ff == GAQ_ENG_RUN && last_x && last_y)
      |=> (!block_ff && eng_ff == GAQ_ENG_IDLE))
    else $error("block flag left after done");
  a_hwrap_back: assert property (
    (ce && eng_ff == GAQ_ENG_RUN && !last_x && hlen != 7'h00
      && hx_ff == hlen - 7'h01) |=> (pat_ptr_ff == $past(pat_row_ff)))
    else $error("pattern pointer not set back");
  a_collect_width: assert property (
    (wr_take && idx == `GAQ_IDX_HDATA && hwidth_ff == 2'h2
      && hbyte_ff != 2'h3) |=> (hword_ff == $past(hword_ff)))
    else $error("host word released early");

  c_queue_full:  cover property (q_full);
  c_sync_stall:  cover property ((psel && penable && stall) ##2 pready_ff);
  c_read_irq:    cover property (!rdirq_ff ##1 rdirq_ff);
  c_engine_done: cover property (block_ff ##1 !block_ff && !busy);

endmodule

/* File: rtl/gaq_defs.svh */
// Purpose: Offsets, field positions and reset values of the accelerator
//          parameter and status register bank.
// Assumes: Register index times four is the APB byte address.
// Notes:   Definitions only.
`ifndef GAQ_DEFS_SVH
`define GAQ_DEFS_SVH

// Register indices (byte address = index * 4)
`define GAQ_IDX_SYNC_EN    8'h32
`define GAQ_IDX_IRQ_MASK   8'h34
`define GAQ_IDX_IRQ_STAT   8'h35
`define GAQ_IDX_STATUS     8'h36
`define GAQ_IDX_CTRL       8'h38
`define GAQ_IDX_HDATA      8'h39
`define GAQ_IDX_HADDR      8'h3a
`define GAQ_IDX_PAT_PTR    8'h3b
`define GAQ_IDX_QUEUED_LO  8'h80
`define GAQ_IDX_PAT_BASE   8'h80
`define GAQ_IDX_SRC_BASE   8'h84
`define GAQ_IDX_PAT_OFF    8'h88
`define GAQ_IDX_SRC_OFF    8'h8a
`define GAQ_IDX_DST_OFF    8'h8c
`define GAQ_IDX_HWIDTH     8'h8e
`define GAQ_IDX_DIR        8'h8f
`define GAQ_IDX_PAT_WRAP   8'h90

// Interrupt status / mask bits
`define GAQ_IRQ_WFAULT     2
`define GAQ_IRQ_READ       1
`define GAQ_IRQ_WRITE      0
// Engine status bits
`define GAQ_ST_SCREEN      3
`define GAQ_ST_BLOCK       2
`define GAQ_ST_BUSY        1
`define GAQ_ST_FULL        0
// Engine control fields
`define GAQ_CTL_START      0
`define GAQ_CTL_SCREEN     1
`define GAQ_CTL_AROUTE_LSB 4
`define GAQ_CTL_DROUTE_LSB 8
`define GAQ_CTL_HCOUNT_LSB 16
`define GAQ_CTL_VCOUNT_LSB 24
// Field widths and positions
`define GAQ_ADDR_W         22
`define GAQ_OFF_W          12
`define GAQ_VWRAP_LSB      4
// Queue
`define GAQ_QDEPTH         3'h4
`define GAQ_QPTR_W         2
// Reset values
`define GAQ_RST_ZERO32     32'h0000_0000
`define GAQ_RST_DIR        2'h0
`define GAQ_RST_WRAP       7'h77

`endif

/* File: rtl/gaq_pkg.sv */
// Purpose: Types shared by the accelerator register bank.
// Assumes: Constants live in gaq_defs.svh.
// Notes:   Types only.
package gaq_pkg;
  typedef enum logic {
    GAQ_ENG_IDLE,
    GAQ_ENG_RUN
  } gaq_eng_state_t;
endpackage

/* File: verification/gaq_host_model.sv */
// Purpose: APB host model that reaches the accelerator register bank.
// Assumes: Requests launch right after a rising edge of pclk.
// Notes:   Released bus shows inverted data so stale values never match.
`timescale 1ns/1ns
module gaq_host_model (
  input  wire logic        pclk,    // Bus clock
  input  wire logic        pready,  // Slave ready
  input  wire logic        pslverr, // Slave error
  input  wire logic [31:0] prdata,  // Read data
  output logic             psel,    // Select
  output logic             penable, // Access phase
  output logic             pwrite,  // Direction
  output logic      [9:0]  paddr,   // Byte address
  output logic      [31:0] pwdata   // Write data
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 10'h000;
    pwdata = 32'h0000_0000;
  end

  // Holds the request until pready is seen high at a rising edge
  task automatic xfer(input logic w, input logic [9:0] a,
                      input logic [31:0] d, output logic [31:0] rd,
                      output logic er, output logic to);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    to = (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule

/* File: verification/tb_top.sv */
// Purpose: Self-checking bench for the accelerator register bank.
// Assumes: Sync enable is 0 until the last scenario, which checks the stall.
// Notes:   Engine runs are kept short except the queue-fill run; busy is polled with a bound.
`timescale 1ns/1ns
`include "gaq_defs.svh"
module tb_top;
  import gaq_pkg::*;
  logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
  logic [9:0]  paddr;
  logic [31:0] pwdata, prdata, rdat, ha;
  logic        err, to;
  int          num_errors, checked, i, j;
  logic [7:0]  fi [8] = '{`GAQ_IDX_PAT_BASE, `GAQ_IDX_SRC_BASE,
    `GAQ_IDX_PAT_OFF, `GAQ_IDX_SRC_OFF, `GAQ_IDX_DST_OFF,
    `GAQ_IDX_HWIDTH, `GAQ_IDX_DIR, `GAQ_IDX_PAT_WRAP};
  logic [31:0] fe [8] = '{32'h003f_ffff, 32'h003f_ffff, 32'h0000_0fff,
    32'h0000_0fff, 32'h0000_0fff, 32'h0000_0003, 32'h0000_0003,
    32'h0000_0077};
  // Host width, control word, direction, writes, address step
  logic [31:0] hw [5] = '{0, 1, 2, 0, 0};
  logic [31:0] hc [5] = '{32'h100, 32'h100, 32'h200, 32'h200, 32'h010};
  logic [31:0] hd [5] = '{0, 0, 0, 1, 0};
  int          hn [5] = '{1, 2, 4, 1, 1};
  int          hs [5] = '{1, 2, 32, -8, 1};

  gaq_regs i_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  gaq_host_model i_host (.pclk(pclk), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata));

  task automatic summarize;
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] s, e);
    checked++;
    if (s !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic acc(input logic w, input logic [7:0] x,
                     input logic [31:0] d);
    i_host.xfer(w, {x, 2'b00}, d, rdat, err, to);
    if (to) begin
      num_errors++;
      summarize();
    end
  endtask

  // Reads of display results only after busy has dropped
  task automatic wait_idle;
    int k;
    for (k = 0; k < 3000; k++) begin
      acc(1'b0, `GAQ_IDX_STATUS, 0);
      if (rdat[`GAQ_ST_BUSY] === 1'b0)
        break;
    end
    if (k == 3000) begin
      num_errors++;
      summarize();
    end
  endtask

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  initial begin
    presetn = 1'b0;
    ce = 1'b1;
    num_errors = 0;
    checked = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    acc(1'b0, `GAQ_IDX_PAT_WRAP, 0);
    chk("wrap_rst", rdat, 32'h77);
    acc(1'b0, `GAQ_IDX_STATUS, 0);
    chk("stat_rst", rdat, 0);
    acc(1'b0, 8'h00, 0);
    chk("unmapped", {31'h0, err}, 1);
    for (i = 0; i < 8; i++) begin
      acc(1'b1, fi[i], 32'hffff_ffff);
      acc(1'b0, fi[i], 0);
      chk("field", rdat, fe[i]);
    end
    ha = 0;
    for (i = 0; i < 5; i++) begin
      acc(1'b1, `GAQ_IDX_HWIDTH, hw[i]);
      acc(1'b1, `GAQ_IDX_DIR, hd[i]);
      acc(1'b1, `GAQ_IDX_CTRL, hc[i]);
      for (j = 0; j < hn[i]; j++)
        acc(1'b1, `GAQ_IDX_HDATA, 32'h5a + j);
      if (i == 2) begin
        acc(1'b0, `GAQ_IDX_HDATA, 0);
        chk("host_word", rdat, 32'h5d5c_5b5a);
      end
      ha = ha + hs[i];
      acc(1'b0, `GAQ_IDX_HADDR, 0);
      chk("host_addr", rdat & 32'h003f_ffff, ha);
    end
    acc(1'b1, `GAQ_IDX_IRQ_MASK, 32'h2);
    acc(1'b1, `GAQ_IDX_CTRL, 32'h003f_0003);
    acc(1'b0, `GAQ_IDX_STATUS, 0);
    chk("stat_run", rdat, 32'he);
    wait_idle();
    chk("stat_done", rdat, 0);
    acc(1'b0, `GAQ_IDX_IRQ_STAT, 0);
    chk("rd_irq", rdat, 32'h2);
    acc(1'b1, `GAQ_IDX_IRQ_STAT, 0);
    acc(1'b0, `GAQ_IDX_IRQ_STAT, 0);
    chk("rd_irq_w0", rdat, 32'h2);
    acc(1'b1, `GAQ_IDX_IRQ_STAT, 32'h2);
    acc(1'b0, `GAQ_IDX_IRQ_STAT, 0);
    chk("rd_irq_clr", rdat, 0);
    acc(1'b1, `GAQ_IDX_IRQ_MASK, 32'h1);
    acc(1'b1, `GAQ_IDX_IRQ_STAT, 32'h1);
    acc(1'b0, `GAQ_IDX_IRQ_STAT, 0);
    chk("wr_irq", rdat, 32'h1);
    acc(1'b1, `GAQ_IDX_IRQ_MASK, 32'h4);
    acc(1'b0, `GAQ_IDX_IRQ_STAT, 0);
    chk("wr_irq_off", rdat, 0);
    // Four-byte tile: eight bytes end three past the base
    acc(1'b1, `GAQ_IDX_PAT_BASE, 32'h100);
    acc(1'b1, `GAQ_IDX_PAT_WRAP, 32'h02);
    acc(1'b1, `GAQ_IDX_CTRL, 32'h0007_0001);
    wait_idle();
    acc(1'b0, `GAQ_IDX_PAT_PTR, 0);
    chk("pat_wrap", rdat, 32'h103);
    // Long run keeps the queue from draining while it is filled
    acc(1'b1, `GAQ_IDX_CTRL, 32'h0fff_0001);
    for (i = 1; i < 6; i++) begin
      acc(1'b1, `GAQ_IDX_PAT_BASE, i);
      if (i == 4) begin
        acc(1'b0, `GAQ_IDX_STATUS, 0);
        chk("stat_full", rdat, 32'h7);
      end
    end
    acc(1'b0, `GAQ_IDX_IRQ_STAT, 0);
    chk("wfault", rdat, 32'h4);
    acc(1'b1, `GAQ_IDX_IRQ_STAT, 32'h4);
    acc(1'b0, `GAQ_IDX_IRQ_STAT, 0);
    chk("wfault_clr", rdat, 0);
    wait_idle();
    acc(1'b0, `GAQ_IDX_PAT_BASE, 0);
    chk("queue_last", rdat, 32'h4);
    // Sync mode: the fifth write waits for room instead of being lost
    acc(1'b1, `GAQ_IDX_SYNC_EN, 32'h1);
    acc(1'b1, `GAQ_IDX_CTRL, 32'h001f_0001);
    for (i = 6; i < 11; i++)
      acc(1'b1, `GAQ_IDX_PAT_BASE, i);
    acc(1'b0, `GAQ_IDX_IRQ_STAT, 0);
    chk("sync_nofault", rdat, 0);
    wait_idle();
    acc(1'b0, `GAQ_IDX_PAT_BASE, 0);
    chk("sync_last", rdat, 32'ha);
    summarize();
  end
endmodule
